// File: verilog/cmc_module_control.sv
// APB register bank of the coprocessor module control with core run control
//
// Local design decisions: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`include "cmc_consts.svh"

module cmc_module_control (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`CMC_ADDR_W-1:0] paddr,
    input wire logic [`CMC_DATA_W-1:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [`CMC_DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic request_pending,
    input wire logic thread_done,
    input wire logic freeze_mode,
    input wire logic sw_breakpoint,
    input wire logic dbg_breakpoint,
    input wire logic sw_error_set,
    input wire logic flag_set,
    output logic coprocessor_flag,
    output logic software_error_flag,
    output logic irq_enable,
    output logic debug_mode_status,
    output logic request_enable,
    output logic halt_in_freeze,
    output logic thread_start,
    output logic core_stall,
    output logic thread_active
);
    cmc_ctl_if ctl_bus ();

    logic req_en_q;
    logic req_en_d;
    logic halt_frz_q;
    logic halt_frz_d;
    logic debug_q;
    logic debug_d;
    logic flag_q;
    logic flag_d;
    logic swerr_q;
    logic swerr_d;
    logic ie_q;
    logic ie_d;
    logic [`CMC_DATA_W-1:0] prdata_q;
    logic [`CMC_DATA_W-1:0] prdata_d;
    logic pready_q;
    logic pready_d;
    logic pslverr_q;
    logic pslverr_d;
    logic hit;
    logic setup;
    logic wr_acc;
    logic wr_lo;
    logic wr_hi;
    logic [`CMC_REG_W-1:0] wdata;

    // Masked update: a bit changes only while its mask is written as one
    function automatic logic masked_update(
        input logic old_value,
        input logic write_en,
        input logic mask,
        input logic new_value
    );
        logic result;
        result = old_value;
        if (write_en && mask) begin
            result = new_value;
        end
        return result;
    endfunction : masked_update

    // Read image; mask positions stay zero
    function automatic logic [`CMC_DATA_W-1:0] read_image(
        input logic req_en,
        input logic halt_frz,
        input logic debug,
        input logic flag,
        input logic swerr,
        input logic ie
    );
        logic [`CMC_DATA_W-1:0] word;
        word = '0;
        word[`CMC_REQ_EN_BIT] = req_en;
        word[`CMC_HALT_FRZ_BIT] = halt_frz;
        word[`CMC_DEBUG_BIT] = debug;
        word[`CMC_FLAG_BIT] = flag;
        word[`CMC_SWERR_BIT] = swerr;
        word[`CMC_IE_BIT] = ie;
        return word;
    endfunction : read_image

    // Bus decode
    always_comb begin
        hit = (paddr == `CMC_MODULE_CONTROL_OFFSET);
        setup = psel & ~penable;
        wr_acc = psel & penable & pwrite & pready_q & hit;
        wr_lo = wr_acc & pstrb[0];
        wr_hi = wr_acc & pstrb[1];
        wdata = pwdata[`CMC_REG_W-1:0];
    end

    // Register next values
    always_comb begin
        req_en_d = req_en_q;
        halt_frz_d = halt_frz_q;
        if (wr_lo) begin
            req_en_d = wdata[`CMC_REQ_EN_BIT];
            halt_frz_d = wdata[`CMC_HALT_FRZ_BIT];
        end
        // Mask bits live only in this write cycle and are not stored
        flag_d = masked_update(flag_q, wr_lo, wr_hi & wdata[`CMC_FLAG_MASK_BIT],
            wdata[`CMC_FLAG_BIT]);
        if (flag_set) begin
            flag_d = 1'b1;
        end
        swerr_d = swerr_q;
        // Writing one with the mask clears; a new error in that cycle wins
        if (wr_lo && wr_hi && wdata[`CMC_SWERR_MASK_BIT] && wdata[`CMC_SWERR_BIT]) begin
            swerr_d = 1'b0;
        end
        if (sw_error_set) begin
            swerr_d = 1'b1;
        end
        ie_d = masked_update(ie_q, wr_lo, wr_hi & wdata[`CMC_IE_MASK_BIT],
            wdata[`CMC_IE_BIT]);
        // Only breakpoints and writes move debug mode; a breakpoint wins
        debug_d = debug_q;
        if (wr_lo) begin
            debug_d = wdata[`CMC_DEBUG_BIT];
        end
        if (sw_breakpoint || dbg_breakpoint) begin
            debug_d = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            req_en_q <= `CMC_REQ_EN_RESET;
            halt_frz_q <= `CMC_HALT_FRZ_RESET;
            debug_q <= `CMC_DEBUG_RESET;
            flag_q <= `CMC_FLAG_RESET;
            swerr_q <= `CMC_SWERR_RESET;
            ie_q <= `CMC_IE_RESET;
        end else begin
            req_en_q <= req_en_d;
            halt_frz_q <= halt_frz_d;
            debug_q <= debug_d;
            flag_q <= flag_d;
            swerr_q <= swerr_d;
            ie_q <= ie_d;
        end
    end

    // APB answer: data and error are prepared in the setup cycle
    always_comb begin
        pready_d = 1'b1;
        prdata_d = prdata_q;
        pslverr_d = pslverr_q;
        if (setup) begin
            pslverr_d = ~hit;
            prdata_d = '0;
            if (!pwrite && hit) begin
                prdata_d = read_image(req_en_q, halt_frz_q, debug_q, flag_q, swerr_q,
                    ie_q);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            prdata_q <= '0;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            prdata_q <= prdata_d;
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
        end
    end

    assign ctl_bus.request_enable = req_en_q;
    assign ctl_bus.halt_in_freeze = halt_frz_q;
    assign ctl_bus.debug_mode = debug_q;

    cmc_core_ctl u_core_ctl (
        .clk(clk),
        .rst_n(rst_n),
        .request_pending(request_pending),
        .thread_done(thread_done),
        .freeze_mode(freeze_mode),
        .ctl(ctl_bus.core)
    );

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign coprocessor_flag = flag_q;
    assign software_error_flag = swerr_q;
    assign irq_enable = ie_q;
    assign debug_mode_status = debug_q;
    assign request_enable = req_en_q;
    assign halt_in_freeze = halt_frz_q;
    assign thread_start = ctl_bus.thread_start;
    assign core_stall = ctl_bus.core_stall;
    assign thread_active = ctl_bus.thread_active;
endmodule : cmc_module_control

// File: verilog/cmc_consts.svh
// Register offsets, field positions, reset values of the coprocessor module control
`ifndef CMC_CONSTS_SVH
`define CMC_CONSTS_SVH
`define CMC_ADDR_W 8
`define CMC_DATA_W 32
`define CMC_REG_W 16
`define CMC_MODULE_CONTROL_OFFSET 8'h00
`define CMC_FLAG_MASK_BIT 11
`define CMC_SWERR_MASK_BIT 9
`define CMC_IE_MASK_BIT 8
`define CMC_REQ_EN_BIT 7
`define CMC_HALT_FRZ_BIT 6
`define CMC_DEBUG_BIT 5
`define CMC_FLAG_BIT 3
`define CMC_SWERR_BIT 1
`define CMC_IE_BIT 0
`define CMC_REQ_EN_RESET 1'b0
`define CMC_HALT_FRZ_RESET 1'b0
`define CMC_DEBUG_RESET 1'b0
`define CMC_FLAG_RESET 1'b0
`define CMC_SWERR_RESET 1'b0
`define CMC_IE_RESET 1'b0
`endif

// File: verilog/cmc_pkg.sv
// Types shared by the coprocessor module control design
package cmc_pkg;
    typedef enum logic [2:0] {
        cmc_idle = 3'b001,
        cmc_run = 3'b010,
        cmc_stopped = 3'b100
    } cmc_core_state_type;
endpackage : cmc_pkg

// File: verilog/cmc_ctl_if.sv
// Control and status signals between the register bank and the core run control
`timescale 1ns/1ps
interface cmc_ctl_if;
    logic request_enable;
    logic halt_in_freeze;
    logic debug_mode;
    logic thread_start;
    logic core_stall;
    logic thread_active;
    modport regs (
        output request_enable,
        output halt_in_freeze,
        output debug_mode,
        input thread_start,
        input core_stall,
        input thread_active
    );
    modport core (
        input request_enable,
        input halt_in_freeze,
        input debug_mode,
        output thread_start,
        output core_stall,
        output thread_active
    );
endinterface : cmc_ctl_if

// File: verilog/cmc_core_ctl.sv
// Request gating and run or stop control of the coprocessor core
`timescale 1ns/1ps
module cmc_core_ctl (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic request_pending,
    input wire logic thread_done,
    input wire logic freeze_mode,
    cmc_ctl_if.core ctl
);
    cmc_pkg::cmc_core_state_type state_q;
    cmc_pkg::cmc_core_state_type state_d;
    logic start_q;
    logic start_d;
    logic stall_q;
    logic stall_d;
    logic active_q;
    logic active_d;
    logic halt;

    always_comb begin
        // Freeze halts only when enabled; debug mode always holds the core
        halt = (freeze_mode & ctl.halt_in_freeze) | ctl.debug_mode;
        state_d = state_q;
        start_d = 1'b0;
        stall_d = halt;
        case (state_q)
            cmc_pkg::cmc_idle: begin
                // New requests only while enabled and the core may run
                if (request_pending && ctl.request_enable && !halt) begin
                    state_d = cmc_pkg::cmc_run;
                    start_d = 1'b1;
                end
            end
            cmc_pkg::cmc_run: begin
                // A cleared request enable does not end the running thread
                if (thread_done) begin
                    state_d = cmc_pkg::cmc_idle;
                end else if (halt) begin
                    state_d = cmc_pkg::cmc_stopped;
                end
            end
            cmc_pkg::cmc_stopped: begin
                // A completion that lands as the core stops is not lost
                if (thread_done) begin
                    state_d = cmc_pkg::cmc_idle;
                end else if (!halt) begin
                    state_d = cmc_pkg::cmc_run;
                end
            end
            default: begin
                state_d = cmc_pkg::cmc_idle;
            end
        endcase
        active_d = (state_d != cmc_pkg::cmc_idle);
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_q <= cmc_pkg::cmc_idle;
            start_q <= 1'b0;
            stall_q <= 1'b0;
            active_q <= 1'b0;
        end else begin
            state_q <= state_d;
            start_q <= start_d;
            stall_q <= stall_d;
            active_q <= active_d;
        end
    end

    assign ctl.thread_start = start_q;
    assign ctl.core_stall = stall_q;
    assign ctl.thread_active = active_q;
endmodule : cmc_core_ctl

// File: verif/cmc_req_src.sv
// Interrupt request source and thread length model facing the coprocessor core
`timescale 1ns/1ps
module cmc_req_src (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic go,
    input wire logic [7:0] dur,
    input wire logic thread_start,
    input wire logic core_stall,
    output logic request_pending,
    output logic thread_done
);
    logic [7:0] cnt_q;
    // A request stays pending until the core takes it; a stalled core makes no progress
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            request_pending <= 1'b0;
            thread_done <= 1'b0;
            cnt_q <= 8'h00;
        end else if (thread_start) begin
            request_pending <= 1'b0;
            thread_done <= 1'b0;
            cnt_q <= dur;
        end else begin
            request_pending <= request_pending | go;
            thread_done <= (cnt_q == 8'h01) && !core_stall;
            if (cnt_q != 8'h00 && !core_stall) begin
                cnt_q <= cnt_q - 8'h01;
            end
        end
    end
endmodule : cmc_req_src

// File: verif/cmc_module_control_checker.sv
// Port assertions of the coprocessor module control
`timescale 1ns/1ps
module cmc_module_control_checker (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic [3:0] pstrb,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic pready,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic request_pending,
    input wire logic thread_done,
    input wire logic freeze_mode,
    input wire logic sw_breakpoint,
    input wire logic dbg_breakpoint,
    input wire logic flag_set,
    input wire logic coprocessor_flag,
    input wire logic software_error_flag,
    input wire logic irq_enable,
    input wire logic debug_mode_status,
    input wire logic request_enable,
    input wire logic halt_in_freeze,
    input wire logic thread_start,
    input wire logic thread_active
);
    logic wr;
    assign wr = psel && penable && pwrite && pready && pstrb[0] && paddr == 8'h00;
    default clocking dc @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence accept_s;
        request_pending && request_enable && !debug_mode_status && !thread_active
            && !(freeze_mode && halt_in_freeze);
    endsequence
    flag_write_a: assert property (wr && pstrb[1] && pwdata[11] && !flag_set |=>
        coprocessor_flag == $past(pwdata[3])) else $error("flag write lost");
    swerr_clear_a: assert property ($fell(software_error_flag) |->
        $past(wr && pwdata[9] && pwdata[1])) else $error("error flag cleared unmasked");
    ie_mask_a: assert property ($changed(irq_enable) |-> $past(wr && pwdata[8]))
        else $error("enable changed unmasked");
    mask_read_a: assert property (prdata[31:8] == 24'h000000)
        else $error("mask bits read nonzero");
    start_gate_a: assert property (thread_start |-> $past(request_pending &&
        request_enable && !(freeze_mode && halt_in_freeze))) else $error("start not allowed");
    accept_a: assert property (accept_s |=> thread_start)
        else $error("request not taken");
    thread_run_a: assert property (thread_active && !thread_done |=> thread_active)
        else $error("thread cut short");
    dbg_enter_a: assert property ($rose(debug_mode_status) |->
        $past(sw_breakpoint || dbg_breakpoint || wr && pwdata[5])) else $error("debug entered");
    dbg_leave_a: assert property ($fell(debug_mode_status) |->
        $past(wr && !pwdata[5])) else $error("debug left");
endmodule : cmc_module_control_checker
bind cmc_module_control cmc_module_control_checker cmc_module_control_checker_inst (.*);

// File: verif/tb_top.sv
// Register and request control bench of the coprocessor module control
`timescale 1ns/1ps
module tb_top;
    logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, go = 1'b0;
    logic freeze_mode = 1'b0, sw_breakpoint = 1'b0, dbg_breakpoint = 1'b0, sw_error_set = 1'b0;
    logic flag_set = 1'b0, pready, pslverr, request_pending, thread_done, err;
    logic coprocessor_flag, software_error_flag, irq_enable, debug_mode_status, request_enable;
    logic halt_in_freeze, thread_start, core_stall, thread_active;
    logic [7:0] paddr = 8'h00, dur = 8'h14;
    logic [3:0] pstrb = 4'hF;
    logic [31:0] pwdata = 32'h00000000, prdata, rd;
    logic [15:0] wv[6] = '{16'h000B, 16'h0B09, 16'h0002, 16'h0202, 16'h0800, 16'h0100};
    logic [15:0] xv[6] = '{16'h0000, 16'h0009, 16'h000B, 16'h0009, 16'h0001, 16'h0008};
    int n_errors = 0, cmp_count = 0, cyc = 0;
    cmc_module_control cmc_module_control_inst (.*);
    cmc_req_src cmc_req_src_inst (.*);
    always #4 clk = ~clk;
    always @(posedge clk) begin
        if (++cyc == 3000) begin
            n_errors++;
            results();
        end
    end
    task results();
        $display("compares %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : results
    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task rchk(input logic [31:0] exp);
        apb(1'b0, 8'h00, 32'h00000000);
        chk(rd, exp);
    endtask : rchk
    task kick();
        @(posedge clk);
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
    endtask : kick
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        rchk(32'h00000000);
        for (int i = 0; i < 6; i++) begin
            @(posedge clk);
            sw_error_set <= i == 2;
            flag_set <= i == 5;
            @(posedge clk);
            {sw_error_set, flag_set} <= 2'h0;
            apb(1'b1, 8'h00, {16'h0000, wv[i]});
            rchk({16'h0000, xv[i]});
        end
        apb(1'b1, 8'h04, 32'h00000B09);
        chk(32'(err), 32'h00000001);
        rchk(32'h00000008);
        pstrb <= 4'h1;
        apb(1'b1, 8'h00, 32'h00000B01);
        pstrb <= 4'hF;
        rchk(32'h00000008);
        $display("register mask test done");
        apb(1'b1, 8'h00, 32'h00000080);
        kick();
        while (thread_active !== 1'b1) @(posedge clk);
        apb(1'b1, 8'h00, 32'h00000000);
        repeat (2) @(posedge clk);
        chk(32'(thread_active), 32'h00000001);
        while (thread_active !== 1'b0) @(posedge clk);
        kick();
        repeat (8) @(posedge clk);
        chk(32'({request_pending, thread_active}), 32'h00000002);
        rchk(32'h00000008);
        $display("request enable test done");
        freeze_mode <= 1'b1;
        apb(1'b1, 8'h00, 32'h000000C0);
        repeat (4) @(posedge clk);
        chk(32'({core_stall, thread_active}), 32'h00000002);
        apb(1'b1, 8'h00, 32'h00000080);
        while (thread_active !== 1'b1) @(posedge clk);
        chk(32'(core_stall), 32'h00000000);
        apb(1'b1, 8'h00, 32'h000000C0);
        repeat (2) @(posedge clk);
        chk(32'({core_stall, thread_active}), 32'h00000003);
        apb(1'b1, 8'h00, 32'h00000080);
        while (thread_active !== 1'b0) @(posedge clk);
        freeze_mode <= 1'b0;
        $display("freeze halt test done");
        for (int i = 0; i < 3; i++) begin
            @(posedge clk);
            sw_breakpoint <= i == 0;
            dbg_breakpoint <= i == 1;
            @(posedge clk);
            {sw_breakpoint, dbg_breakpoint, sw_error_set, freeze_mode} <= 4'h3;
            @(posedge clk);
            {sw_error_set, freeze_mode} <= 2'h0;
            if (i == 2) apb(1'b1, 8'h00, 32'h000000A0);
            rchk(32'h000000AA);
            apb(1'b1, 8'h00, 32'h00000282);
            rchk(32'h00000088);
        end
        $display("debug mode test done");
        results();
    end
endmodule : tb_top
